// [hw/mmp_defs.svh]
// constants for the media port: widths, reset values, buffer shape
//
// Overview of operation
// - transmit nibble changes with transmit clock
// - transmit enable marks exactly the valid nibbles
// - half duplex collision input means medium collision
// - full duplex: no frame start during collision
// - receive nibbles accepted only while valid asserted
// - receive coding error marks the reception errored
// - terminals default to host port function
`ifndef MMP_DEFS_SVH
`define MMP_DEFS_SVH

`define MMP_NIB_W 4
`define MMP_NIB_ZERO 4'h0
`define MMP_FIFO_W 5
`define MMP_FIFO_DEPTH 4
`define MMP_SYNC_W 10
`define MMP_SYNC_ZERO 10'h000

`endif

// [hw/mmp_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module mmp_fifo #(
  parameter int W = 5,
  parameter int D = 4
) (
  input wire logic clk,     // system clock
  input wire logic rst,     // synchronous reset, active high
  mmp_stream_if.snk wr,     // filling side
  mmp_stream_if.src rd      // draining side
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic room_r;
  logic push;
  logic pop;

  // registered so the filling side sees a flop
  assign wr.ready = room_r;
  assign rd.valid = (cnt_r != '0);
  assign rd.data = mem[rp_r];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      end
    end
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      room_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      room_r <= (cnt_nxt != CW'(D));
    end
  end

  chk_fifo_bound: assert property (@(posedge clk) disable iff (rst) cnt_r <= CW'(D))
    else $error("fifo count beyond depth");
endmodule

// [hw/mmp_pkg.sv]
// types shared by the media port modules
package mmp_pkg;

  // transmit sequencer states
  typedef enum logic [2:0] {
    MMP_TX_IDLE = 3'b001,
    MMP_TX_SEND = 3'b010,
    MMP_TX_DROP = 3'b100
  } mmp_tx_e;

endpackage

// [hw/mmp_stream_if.sv]
// valid/ready stream carrier between the media port modules
`timescale 1ns/1ps
interface mmp_stream_if #(
  parameter int W = 5
) ();
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

// [hw/mmp_top.sv]
// media independent interface port: nibble transmit and receive with the PHY
`timescale 1ns/1ps
`include "mmp_defs.svh"
module mmp_top #(
  parameter int FIFO_DEPTH = `MMP_FIFO_DEPTH
) (
  input wire logic clk,                            // system clock, 125 MHz
  input wire logic rst,                            // synchronous reset, active high
  input wire logic eth_select,                     // config: terminals carry mac function
  input wire logic full_duplex,                    // config: 1 full, 0 half duplex
  input wire logic [`MMP_NIB_W-1:0] tx_in_data,    // nibble to send
  input wire logic tx_in_last,                     // nibble closes the frame
  input wire logic tx_in_valid,                    // nibble offered
  output logic tx_in_ready,                        // buffer can take a nibble
  input wire logic tx_nibble_clock,                // transmit clock from the PHY
  output logic [`MMP_NIB_W-1:0] tx_nibble_lines,   // transmit nibble pins
  output logic tx_nibble_enable,                   // transmit enable pin
  output logic mii_tx_oe,                          // drive enable of transmit terminals
  input wire logic collision_sense,                // collision pin
  input wire logic carrier_sense,                  // carrier pin
  input wire logic rx_nibble_clock,                // receive clock from the PHY
  input wire logic [`MMP_NIB_W-1:0] rx_nibble_lines, // receive nibble pins
  input wire logic rx_nibble_valid,                // receive data valid pin
  input wire logic rx_coding_error,                // receive error pin
  output logic [`MMP_NIB_W-1:0] rx_out_data,       // received nibble
  output logic rx_out_error,                       // nibble came with coding error
  output logic rx_out_valid,                       // received nibble pulse
  output logic rx_frame_end,                       // end of reception pulse
  output logic rx_frame_bad,                       // reception errored, with end pulse
  output logic carrier_out,                        // carrier level, synchronised
  output logic collision_out,                      // collision level, synchronised
  output logic tx_collision,                       // pulse: frame aborted by collision
  output logic tx_underrun                         // pulse: frame aborted, buffer empty
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [`MMP_SYNC_W-1:0] pin_s1_r;
  logic [`MMP_SYNC_W-1:0] pin_s2_r;
  logic tx_clk_d_r;
  logic rx_clk_d_r;
  logic eth_sel_r;
  logic tx_clk_s;
  logic rx_clk_s;
  logic col_s;
  logic crs_s;
  logic rx_dv_s;
  logic rx_er_s;
  logic [`MMP_NIB_W-1:0] rx_d_s;
  logic tx_rise;
  logic rx_fall;
  logic hd_col;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_r <= `MMP_SYNC_ZERO;
      pin_s2_r <= `MMP_SYNC_ZERO;
    end else begin
      pin_s1_r <= {tx_nibble_clock, rx_nibble_clock, collision_sense, carrier_sense,
                   rx_nibble_valid, rx_coding_error, rx_nibble_lines};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign {tx_clk_s, rx_clk_s, col_s, crs_s, rx_dv_s, rx_er_s, rx_d_s} = pin_s2_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_clk_d_r <= 1'b0;
      rx_clk_d_r <= 1'b0;
    end else begin
      tx_clk_d_r <= tx_clk_s;
      rx_clk_d_r <= rx_clk_s;
    end
  end

  // default is host port function until selected
  always_ff @(posedge clk) begin
    if (rst) begin
      eth_sel_r <= 1'b0;
      mii_tx_oe <= 1'b0;
    end else begin
      eth_sel_r <= eth_select;
      mii_tx_oe <= eth_sel_r;
    end
  end

  assign tx_rise = tx_clk_s && !tx_clk_d_r;
  assign rx_fall = !rx_clk_s && rx_clk_d_r;
  assign hd_col = !full_duplex && col_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      carrier_out <= 1'b0;
      collision_out <= 1'b0;
    end else begin
      carrier_out <= crs_s;
      collision_out <= col_s;
    end
  end

  // ************************************************************
  // transmit buffer
  // ************************************************************
  mmp_stream_if #(.W(`MMP_FIFO_W)) fifo_in ();
  mmp_stream_if #(.W(`MMP_FIFO_W)) fifo_out ();

  assign fifo_in.data = {tx_in_last, tx_in_data};
  assign fifo_in.valid = tx_in_valid;
  assign tx_in_ready = fifo_in.ready;

  mmp_fifo #(
    .W(`MMP_FIFO_W),
    .D(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .wr(fifo_in),
    .rd(fifo_out)
  );

  // ************************************************************
  // transmit sequencer
  // ************************************************************
  mmp_pkg::mmp_tx_e tx_st_r;
  logic tx_pop;
  logic f_last;
  logic [`MMP_NIB_W-1:0] f_nib;

  assign {f_last, f_nib} = fifo_out.data;
  assign fifo_out.ready = tx_pop;

  always_comb begin
    tx_pop = 1'b0;
    unique case (tx_st_r)
      mmp_pkg::MMP_TX_IDLE: begin
        tx_pop = tx_rise && eth_sel_r && fifo_out.valid && !(full_duplex && col_s);
      end
      mmp_pkg::MMP_TX_SEND: begin
        tx_pop = tx_rise && eth_sel_r && fifo_out.valid && !hd_col;
      end
      mmp_pkg::MMP_TX_DROP: begin
        tx_pop = fifo_out.valid;
      end
      default: begin
        tx_pop = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_st_r <= mmp_pkg::MMP_TX_IDLE;
    end else begin
      unique case (tx_st_r)
        mmp_pkg::MMP_TX_IDLE: begin
          if (tx_pop && !f_last) begin
            tx_st_r <= mmp_pkg::MMP_TX_SEND;
          end
        end
        mmp_pkg::MMP_TX_SEND: begin
          if (!eth_sel_r) begin
            tx_st_r <= mmp_pkg::MMP_TX_DROP;
          end else if (tx_rise) begin
            if (hd_col || !fifo_out.valid) begin
              tx_st_r <= mmp_pkg::MMP_TX_DROP;
            end else if (f_last) begin
              tx_st_r <= mmp_pkg::MMP_TX_IDLE;
            end
          end
        end
        mmp_pkg::MMP_TX_DROP: begin
          if (tx_pop && f_last) begin
            tx_st_r <= mmp_pkg::MMP_TX_IDLE;
          end
        end
        default: begin
          tx_st_r <= mmp_pkg::MMP_TX_IDLE;
        end
      endcase
    end
  end

  // pins change only after a transmit clock rise, or go quiet while host port function is selected
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_nibble_lines <= `MMP_NIB_ZERO;
      tx_nibble_enable <= 1'b0;
    end else if (!eth_sel_r) begin
      tx_nibble_lines <= `MMP_NIB_ZERO;
      tx_nibble_enable <= 1'b0;
    end else if (tx_rise) begin
      if (tx_pop && tx_st_r != mmp_pkg::MMP_TX_DROP) begin
        tx_nibble_lines <= f_nib;
        tx_nibble_enable <= 1'b1;
      end else begin
        tx_nibble_lines <= `MMP_NIB_ZERO;
        tx_nibble_enable <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_collision <= 1'b0;
      tx_underrun <= 1'b0;
    end else begin
      tx_collision <= 1'b0;
      tx_underrun <= 1'b0;
      if (eth_sel_r && tx_rise && tx_st_r == mmp_pkg::MMP_TX_SEND) begin
        tx_collision <= hd_col;
        tx_underrun <= !hd_col && !fifo_out.valid;
      end
    end
  end

  // ************************************************************
  // receive path
  // ************************************************************
  logic rx_in_frame_r;
  logic rx_err_acc_r;

  // data launched on the rise is stable by the fall
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_out_data <= `MMP_NIB_ZERO;
      rx_out_error <= 1'b0;
      rx_out_valid <= 1'b0;
      rx_frame_end <= 1'b0;
      rx_frame_bad <= 1'b0;
      rx_in_frame_r <= 1'b0;
      rx_err_acc_r <= 1'b0;
    end else begin
      rx_out_valid <= 1'b0;
      rx_frame_end <= 1'b0;
      if (eth_sel_r && rx_fall) begin
        if (rx_dv_s) begin
          rx_out_data <= rx_d_s;
          rx_out_error <= rx_er_s;
          rx_out_valid <= 1'b1;
          rx_in_frame_r <= 1'b1;
          rx_err_acc_r <= (rx_in_frame_r && rx_err_acc_r) || rx_er_s;
        end else if (rx_in_frame_r) begin
          rx_frame_end <= 1'b1;
          rx_frame_bad <= rx_err_acc_r;
          rx_in_frame_r <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic chk_err_seen_r;

  always_ff @(posedge clk) begin
    if (rst || rx_frame_end) begin
      chk_err_seen_r <= 1'b0;
    end else if (rx_out_valid && rx_out_error) begin
      chk_err_seen_r <= 1'b1;
    end
  end

  chk_tx_idle_zero: assert property (@(posedge clk) disable iff (rst)
    !tx_nibble_enable |-> tx_nibble_lines == `MMP_NIB_ZERO)
    else $error("transmit lines not quiet while enable low");

  chk_tx_clock_sync: assert property (@(posedge clk) disable iff (rst)
    ($changed(tx_nibble_lines) || $changed(tx_nibble_enable))
      |-> ($past(tx_rise) || !$past(eth_sel_r)))
    else $error("transmit pins changed away from transmit clock rise");

  chk_tx_data_src: assert property (@(posedge clk) disable iff (rst)
    (tx_rise && tx_pop && eth_sel_r && tx_st_r != mmp_pkg::MMP_TX_DROP)
      |=> tx_nibble_enable && tx_nibble_lines == $past(f_nib))
    else $error("transmit nibble not taken from buffer");

  chk_fd_defer: assert property (@(posedge clk) disable iff (rst)
    (tx_st_r == mmp_pkg::MMP_TX_IDLE && full_duplex && col_s) |=> !$rose(tx_nibble_enable))
    else $error("frame started during full duplex collision");

  chk_hd_abort: assert property (@(posedge clk) disable iff (rst)
    (eth_sel_r && tx_rise && hd_col && tx_st_r == mmp_pkg::MMP_TX_SEND)
      |=> tx_collision && !tx_nibble_enable ##1 !tx_collision)
    else $error("half duplex collision not acted on");

  chk_host_default: assert property (@(posedge clk) disable iff (rst)
    !eth_sel_r |=> !mii_tx_oe && !tx_nibble_enable && !rx_out_valid)
    else $error("mac drives terminals while host port selected");

  chk_rx_valid_only: assert property (@(posedge clk) disable iff (rst)
    rx_out_valid |-> $past(rx_fall) && $past(rx_dv_s))
    else $error("nibble accepted without receive valid");

  chk_rx_sample: assert property (@(posedge clk) disable iff (rst)
    rx_out_valid |-> rx_out_data == $past(rx_d_s) && rx_out_error == $past(rx_er_s))
    else $error("received nibble not the sampled pins");

  chk_rx_err_mark: assert property (@(posedge clk) disable iff (rst)
    (rx_frame_end && chk_err_seen_r) |-> rx_frame_bad)
    else $error("errored reception not flagged");

  cov_tx_frame: cover property (@(posedge clk) disable iff (rst)
    $fell(tx_nibble_enable) && tx_st_r == mmp_pkg::MMP_TX_IDLE);

  cov_hd_collision: cover property (@(posedge clk) disable iff (rst) tx_collision);

  cov_fd_defer: cover property (@(posedge clk) disable iff (rst)
    tx_rise && full_duplex && col_s && fifo_out.valid && tx_st_r == mmp_pkg::MMP_TX_IDLE);

  cov_rx_bad: cover property (@(posedge clk) disable iff (rst) rx_frame_end && rx_frame_bad);

endmodule

// [verification/mmp_phy_model.sv]
// behavioural PHY at the far side of the media port
`timescale 1ns/1ps
`include "mmp_defs.svh"
module mmp_phy_model (
  input wire logic tx_run,                           // let the transmit clock run
  input wire logic col_in,                           // collision level to present
  output logic tx_nibble_clock,                      // transmit clock to the mac
  input wire logic [`MMP_NIB_W-1:0] tx_nibble_lines, // transmit nibble from the mac
  input wire logic tx_nibble_enable,                 // transmit enable from the mac
  output logic collision_sense,                      // collision pin
  output logic carrier_sense,                        // carrier pin
  output logic rx_nibble_clock,                      // receive clock to the mac
  output logic [`MMP_NIB_W-1:0] rx_nibble_lines,     // receive nibble pins
  output logic rx_nibble_valid,                      // receive valid pin
  output logic rx_coding_error                       // receive error pin
);
  logic [`MMP_NIB_W-1:0] cap[$];
  // ************
  // transmit side
  // ************
  initial begin
    tx_nibble_clock = 1'b0;
    #5;
    forever begin
      #32;
      if (tx_run) begin
        tx_nibble_clock = ~tx_nibble_clock;
      end
    end
  end
  always @(posedge tx_nibble_clock) begin
    if (tx_nibble_enable === 1'b1) begin
      cap.push_back(tx_nibble_lines);
    end
  end
  assign collision_sense = col_in;
  // ************
  // receive side
  // ************
  initial begin
    rx_nibble_clock = 1'b0;
    rx_nibble_lines = 4'h0;
    rx_nibble_valid = 1'b0;
    rx_coding_error = 1'b0;
    carrier_sense = 1'b0;
  end
  task automatic rx_frame(input logic [`MMP_NIB_W-1:0] q[$], input int err_at);
    #2; // keep receive pin edges off the system clock edge
    for (int i = 0; i < q.size() + 2; i++) begin
      rx_nibble_clock = 1'b1;
      #1;
      if (i < q.size()) begin
        rx_nibble_lines = q[i];
        rx_nibble_valid = 1'b1;
        rx_coding_error = (i == err_at);
        carrier_sense = 1'b1;
      end else begin
        rx_nibble_lines = ~rx_nibble_lines;
        rx_nibble_valid = 1'b0;
        rx_coding_error = 1'b0;
        carrier_sense = 1'b0;
      end
      #31;
      rx_nibble_clock = 1'b0;
      #32;
    end
  endtask
endmodule

// [verification/mmp_top_tb.sv]
// self-checking bench for the media port
`timescale 1ns/1ps
`include "mmp_defs.svh"
module mmp_top_tb;
  logic clk, rst, eth_select, full_duplex, tx_in_last, tx_in_valid, tx_in_ready;
  logic [`MMP_NIB_W-1:0] tx_in_data, tx_nibble_lines, rx_nibble_lines, rx_out_data;
  logic tx_nibble_clock, tx_nibble_enable, mii_tx_oe, collision_sense, carrier_sense;
  logic rx_nibble_clock, rx_nibble_valid, rx_coding_error, rx_out_error, rx_out_valid;
  logic rx_frame_end, rx_frame_bad, carrier_out, collision_out, tx_collision, tx_underrun;
  logic tx_run, col_in, last_bad;
  logic [`MMP_NIB_W-1:0] exp_tx[$], rq[$], got_d[$];
  logic got_e[$];
  int err_total = 0, total_checks = 0, ends = 0, col_seen = 0, und_seen = 0;
  mmp_top #(.FIFO_DEPTH(4)) mmp_top_i (.clk(clk), .rst(rst), .eth_select(eth_select),
    .full_duplex(full_duplex), .tx_in_data(tx_in_data), .tx_in_last(tx_in_last),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_nibble_clock(tx_nibble_clock),
    .tx_nibble_lines(tx_nibble_lines), .tx_nibble_enable(tx_nibble_enable),
    .mii_tx_oe(mii_tx_oe), .collision_sense(collision_sense), .carrier_sense(carrier_sense),
    .rx_nibble_clock(rx_nibble_clock), .rx_nibble_lines(rx_nibble_lines),
    .rx_nibble_valid(rx_nibble_valid), .rx_coding_error(rx_coding_error),
    .rx_out_data(rx_out_data), .rx_out_error(rx_out_error), .rx_out_valid(rx_out_valid),
    .rx_frame_end(rx_frame_end), .rx_frame_bad(rx_frame_bad), .carrier_out(carrier_out),
    .collision_out(collision_out), .tx_collision(tx_collision), .tx_underrun(tx_underrun));
  mmp_phy_model phy_i (.tx_run(tx_run), .col_in(col_in), .tx_nibble_clock(tx_nibble_clock),
    .tx_nibble_lines(tx_nibble_lines), .tx_nibble_enable(tx_nibble_enable),
    .collision_sense(collision_sense), .carrier_sense(carrier_sense),
    .rx_nibble_clock(rx_nibble_clock), .rx_nibble_lines(rx_nibble_lines),
    .rx_nibble_valid(rx_nibble_valid), .rx_coding_error(rx_coding_error));
  // ************
  // helpers
  // ************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic push(input logic [3:0] d, input logic l);
    tx_in_data <= d;
    tx_in_last <= l;
    tx_in_valid <= 1'b1;
    do @(posedge clk); while (tx_in_ready !== 1'b1);
  endtask
  task automatic send(input int n);
    logic [3:0] d;
    for (int i = 0; i < n; i++) begin
      d = 4'($urandom());
      exp_tx.push_back(d);
      push(d, i == n - 1);
    end
    tx_in_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_tx(input int n);
    for (int i = 0; i < 3000 && phy_i.cap.size() < n; i++) @(posedge clk);
  endtask
  task automatic cmp_tx();
    chk("tx count", 8'(exp_tx.size()), 8'(phy_i.cap.size()));
    foreach (exp_tx[i]) chk("tx nibble", 8'(exp_tx[i]), 8'(phy_i.cap[i]));
    exp_tx.delete();
    phy_i.cap.delete();
  endtask
  task automatic rx_run(input int n, input int err_at, input int exp_n);
    rq.delete();
    for (int i = 0; i < n; i++) rq.push_back(4'($urandom()));
    phy_i.rx_frame(rq, err_at);
    repeat (10) @(posedge clk);
    chk("rx count", 8'(exp_n), 8'(got_d.size()));
    for (int i = 0; i < exp_n && i < got_d.size(); i++) begin
      chk("rx nibble", 8'(rq[i]), 8'(got_d[i]));
      chk("rx error", 8'(i == err_at), 8'(got_e[i]));
    end
    chk("rx ends", 8'(exp_n > 0), 8'(ends));
    if (exp_n > 0) chk("rx bad", 8'(err_at >= 0), 8'(last_bad));
    got_d.delete();
    got_e.delete();
    ends = 0;
  endtask
  always @(posedge clk) begin
    if (rx_out_valid === 1'b1) begin
      got_d.push_back(rx_out_data);
      got_e.push_back(rx_out_error);
      chk("carrier_out", 8'h01, 8'(carrier_out));
    end
    if (rx_frame_end === 1'b1) begin
      ends++;
      last_bad = rx_frame_bad;
    end
    if (tx_collision === 1'b1) col_seen++;
    if (tx_underrun === 1'b1) und_seen++;
  end
  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end
  // ************
  // main sequence
  // ************
  initial begin
    rst = 1'b1; eth_select = 1'b0; full_duplex = 1'b0; tx_in_data = 4'h0;
    tx_in_last = 1'b0; tx_in_valid = 1'b0; tx_run = 1'b0; col_in = 1'b0;
    void'($urandom(80));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("ready after reset", 8'h01, 8'(tx_in_ready));
    chk("oe default", 8'h00, 8'(mii_tx_oe));
    rx_run(3, -1, 0);
    chk("oe default", 8'h00, 8'(mii_tx_oe));
    eth_select <= 1'b1;
    repeat (4) @(posedge clk);
    chk("oe selected", 8'h01, 8'(mii_tx_oe));
    rx_run(5, 2, 5);
    rx_run(4, -1, 4);
    send(4);
    @(posedge clk);
    chk("ready when full", 8'h00, 8'(tx_in_ready));
    chk("enable without clock", 8'h00, 8'(tx_nibble_enable));
    tx_run = 1'b1;
    wait_tx(4);
    cmp_tx();
    send(6);
    send(3);
    wait_tx(9);
    repeat (20) @(posedge clk);
    cmp_tx();
    full_duplex <= 1'b1;
    col_in <= 1'b1;
    @(posedge clk);
    send(3);
    repeat (60) @(posedge clk);
    chk("deferred count", 8'h00, 8'(phy_i.cap.size()));
    col_in <= 1'b0;
    wait_tx(3);
    repeat (20) @(posedge clk);
    cmp_tx();
    full_duplex <= 1'b0;
    send(4);
    for (int i = 0; i < 200 && tx_nibble_enable !== 1'b1; i++) @(posedge clk);
    col_in <= 1'b1;
    repeat (40) @(posedge clk);
    chk("collision pulse", 8'h01, 8'(col_seen));
    chk("collision_out", 8'h01, 8'(collision_out));
    chk("enable after collision", 8'h00, 8'(tx_nibble_enable));
    chk("ready after discard", 8'h01, 8'(tx_in_ready));
    chk("aborted count", 8'h01, 8'(phy_i.cap.size()));
    col_in <= 1'b0;
    exp_tx.delete();
    phy_i.cap.delete();
    push(4'h5, 1'b0);
    tx_in_valid <= 1'b0;
    repeat (40) @(posedge clk);
    push(4'h6, 1'b1);
    tx_in_valid <= 1'b0;
    repeat (20) @(posedge clk);
    chk("underrun pulse", 8'h01, 8'(und_seen));
    chk("underrun count", 8'h01, 8'(phy_i.cap.size()));
    chk("underrun nibble", 8'h05, 8'(phy_i.cap[0]));
    chk("enable after underrun", 8'h00, 8'(tx_nibble_enable));
    phy_i.cap.delete();
    send(2);
    wait_tx(2);
    repeat (20) @(posedge clk);
    cmp_tx();
    tally_and_finish();
  end
endmodule
